// File: rtl/tcr_pkg.sv
// Shared constants for the two-wire temperature register read port
// Operation
// - Reads start at last written pointer register
// - Acknowledged byte advances internal byte address
// - Sequential read runs until controller stop
// - Pointers 0,1,2 select hot, delta, cold
// - Pointer set: start, write address, pointer, stop
// - Read: start then address with read bit
// - Two-byte read: ack upper, nak lower, stop
// - Sign in upper bit 7, sixteenth-degree scale
// - Pointer is write-only, never read back
// - Six pointer bits, reset zero, upper bits zero
// - Temperature and raw registers ignore writes
// - Controller writes pointer before register access
// - Pointer kept across transactions
// - Device stretches clock after acknowledge falling edge
// - Acknowledge only a matching strap address
// - Start or stop mid-byte releases data, abandons
package tcr_pkg;
  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [5:0] TCR_IDX_HOT = 6'h00;
  localparam logic [5:0] TCR_IDX_DIFF = 6'h01;
  localparam logic [5:0] TCR_IDX_COLD = 6'h02;
  localparam logic [5:0] TCR_IDX_RAW = 6'h03;
  localparam logic [5:0] TCR_PTR_RESET = 6'h00;
  // ---------------------------------------------------------------
  // Address and field layout
  // ---------------------------------------------------------------
  localparam logic [3:0] TCR_ADDR_BASE = 4'h0_00C;   // Upper address bits 1100
  localparam int TCR_SIGN_BIT = 7;                   // Sign bit in upper byte
  localparam logic [7:0] TCR_SIGN_MASK = 8'h0_080;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int TCR_CLK_HZ = 100_000_000;
  localparam int TCR_STRETCH_NS = 2000;               // Hold interval, own choice
  localparam int TCR_STRETCH_CYC = (TCR_STRETCH_NS * (TCR_CLK_HZ / 1_000_000)) / 1000;
  localparam int TCR_HALF_CYC = 40;                    // Controller quarter-bit phase, 400 ns
  // ---------------------------------------------------------------
  // Controller commands
  // ---------------------------------------------------------------
  localparam logic [7:0] TCR_CMD_OFF = 8'h0_000;
  localparam logic [7:0] TCR_CMD_PTR = 8'h0_004;
  localparam logic [7:0] TCR_CMD_READ = 8'h0_008;
  localparam logic [7:0] TCR_CMD_DATA = 8'h0_00C;
  localparam logic [7:0] TCR_CMD_STAT = 8'h0_010;
endpackage

// File: rtl/tcr_link_if.sv
// Two-wire link between controller and temperature device
`timescale 1ns/10ps
`default_nettype none
interface tcr_link_if;
  // Controller drives
  logic ctl_scl_oe;
  logic ctl_sda_oe;
  // Device drives
  logic dev_scl_oe;
  logic dev_sda_oe;
  // Resolved open-drain wire levels
  logic scl;
  logic sda;
  assign scl = ~(ctl_scl_oe | dev_scl_oe);
  assign sda = ~(ctl_sda_oe | dev_sda_oe);
  modport device (input scl, input sda, output dev_scl_oe, output dev_sda_oe);
  modport controller (input scl, input sda, output ctl_scl_oe, output ctl_sda_oe);
endinterface
`default_nettype wire

// File: rtl/tcr_device.sv
// Device end: two-wire target serving temperature registers
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module tcr_device #(
  parameter int STRETCH_CYC = tcr_pkg::TCR_STRETCH_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Strap and register values
  input wire logic [2:0] i_addr_strap,
  input wire logic [15:0] i_hot_temp,
  input wire logic [15:0] i_diff_temp,
  input wire logic [15:0] i_cold_temp,
  input wire logic [15:0] i_raw_data,
  // Link
  tcr_link_if.device link,
  // Status
  output logic [5:0] o_pointer
);
  import tcr_pkg::*;
  // Stretch counter is 16 bits wide; refuse counts it cannot hold
  if (STRETCH_CYC < 1 || STRETCH_CYC > 65535) begin : g_bad_stretch
    $error("stretch count out of range");
  end
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000, DS_ADDR = 3'b001, DS_WR = 3'b010,
    DS_TX = 3'b011, DS_ACKIN = 3'b100, DS_SKIP = 3'b101
  } tcr_dstate_type;
  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0] scl_s_q, sda_s_q;  // Two-stage synchronisers
  logic scl_q, sda_q;            // Third stage, for edges
  logic [2:0] strap_a_q;         // Strap pin, first stage
  logic [2:0] strap_b_q;         // Strap pin, second stage, the only one read
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      strap_a_q <= 3'h0;
      strap_b_q <= 3'h0;
    end else begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
      strap_a_q <= i_addr_strap;
      strap_b_q <= strap_a_q;
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s_q[1] & ~scl_q;
  assign scl_fall = ~scl_s_q[1] & scl_q;
  assign start_c = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
  assign stop_c = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
  // ---------------------------------------------------------------
  // Register selection
  // ---------------------------------------------------------------
  // Byte address: register index and half select
  function automatic logic [7:0] read_byte(input logic [5:0] idx, input logic lo);
    logic [15:0] w;
    w = 16'h0_000;
    case (idx)
      TCR_IDX_HOT: w = i_hot_temp;
      TCR_IDX_DIFF: w = i_diff_temp;
      TCR_IDX_COLD: w = i_cold_temp;
      TCR_IDX_RAW: w = i_raw_data;
      default: w = 16'h0_000;
    endcase
    // Upper byte first, sign in bit 7 passes unchanged
    read_byte = lo ? w[7:0] : w[15:8];
  endfunction
  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  tcr_dstate_type st_q;
  logic [7:0] sh_q;        // Shift register
  logic [3:0] bit_q;       // Bits seen in this byte
  logic ack_phase_q;       // In acknowledge slot
  logic [5:0] ptr_q;       // Written pointer
  logic [5:0] rd_idx_q;    // Running read index
  logic rd_lo_q;           // Low half next
  logic sda_oe_q, scl_oe_q;
  logic [15:0] str_cnt_q;  // Stretch counter
  logic pend_load_q;       // Load next byte at clock fall, then stretch
  logic [7:0] next_byte;   // Byte that the running read index selects
  // Process form keeps the register inputs read by the function in view
  always_comb begin
    next_byte = read_byte(rd_idx_q, rd_lo_q);
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= DS_IDLE;
      sh_q <= 8'h0_000;
      bit_q <= 4'h0_000;
      ack_phase_q <= 1'b0;
      ptr_q <= TCR_PTR_RESET;
      rd_idx_q <= TCR_PTR_RESET;
      rd_lo_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      str_cnt_q <= 16'h0_000;
      pend_load_q <= 1'b0;
    end else if (stop_c) begin
      // Stop ends any transfer and frees the wires
      st_q <= DS_IDLE;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      pend_load_q <= 1'b0;
    end else if (start_c) begin
      st_q <= DS_ADDR;
      bit_q <= 4'h0_000;
      // Every transaction restarts at the kept pointer, upper half first
      rd_idx_q <= ptr_q;
      rd_lo_q <= 1'b0;
      ack_phase_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      pend_load_q <= 1'b0;
    end else if (scl_oe_q) begin
      // Hold clock low with next byte already on the data line, then release
      if (str_cnt_q == 16'(STRETCH_CYC - 1)) begin
        scl_oe_q <= 1'b0;
      end else begin
        str_cnt_q <= str_cnt_q + 16'h0_001;
      end
    end else begin
      case (st_q)
        DS_ADDR, DS_WR: begin
          if (scl_rise && !ack_phase_q) begin
            sh_q <= {sh_q[6:0], sda_s_q[1]};
            bit_q <= bit_q + 4'h0_001;
          end else if (scl_fall && !ack_phase_q && bit_q == 4'h0_008) begin
            if (st_q == DS_WR) begin
              // Only the six low bits are kept
              ptr_q <= sh_q[5:0];
              rd_idx_q <= sh_q[5:0];
              rd_lo_q <= 1'b0;
              sda_oe_q <= 1'b1;
              ack_phase_q <= 1'b1;
            end else if (sh_q[7:1] == {TCR_ADDR_BASE, strap_b_q}) begin
              sda_oe_q <= 1'b1;
              ack_phase_q <= 1'b1;
            end else begin
              st_q <= DS_SKIP;      // Not addressed
            end
          end else if (scl_fall && ack_phase_q) begin
            ack_phase_q <= 1'b0;
            bit_q <= 4'h0_000;
            sda_oe_q <= 1'b0;
            if (st_q == DS_ADDR && sh_q[0]) begin
              // Read begins at last pointer
              st_q <= DS_TX;
              sh_q <= next_byte;
              // First bit goes out now, settled long before the clock is let go
              sda_oe_q <= ~next_byte[7];
              scl_oe_q <= 1'b1;
              str_cnt_q <= 16'h0_000;
            end else if (st_q == DS_ADDR) begin
              st_q <= DS_WR;
            end else begin
              // Further written bytes are ignored
              st_q <= DS_SKIP;
            end
          end
        end
        DS_TX: begin
          if (scl_fall) begin
            if (bit_q == 4'h0_007) begin
              sda_oe_q <= 1'b0;
              st_q <= DS_ACKIN;
              bit_q <= 4'h0_000;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_q <= ~sh_q[6];
              bit_q <= bit_q + 4'h0_001;
            end
          end
        end
        DS_ACKIN: begin
          if (scl_rise) begin
            pend_load_q <= ~sda_s_q[1];
            if (!sda_s_q[1]) begin
              // Acknowledged: advance byte address
              rd_lo_q <= ~rd_lo_q;
              rd_idx_q <= rd_lo_q ? rd_idx_q + 6'h01 : rd_idx_q;
            end
          end else if (scl_fall) begin
            if (pend_load_q) begin
              st_q <= DS_TX;
              sh_q <= next_byte;
              sda_oe_q <= ~next_byte[7];
              scl_oe_q <= 1'b1;
              str_cnt_q <= 16'h0_000;
            end else begin
              st_q <= DS_SKIP;      // Not acknowledged: wait for stop
            end
          end
        end
        default: begin
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end
  assign link.dev_sda_oe = sda_oe_q;
  assign link.dev_scl_oe = scl_oe_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pointer <= TCR_PTR_RESET;
    end else begin
      o_pointer <= ptr_q;
    end
  end
endmodule
`default_nettype wire

// File: rtl/tcr_controller.sv
// Controller end: register-driven two-wire bus controller
`timescale 1ns/10ps
`default_nettype none
module tcr_controller #(
  parameter int HALF_CYC = tcr_pkg::TCR_HALF_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Link
  tcr_link_if.controller link
);
  import tcr_pkg::*;
  // Phase timer is 16 bits wide and needs a few cycles per quarter
  if (HALF_CYC < 4 || HALF_CYC > 65535) begin : g_bad_half
    $error("half period out of range");
  end
  typedef enum logic [2:0] {
    CS_IDLE = 3'b000, CS_START = 3'b001, CS_BIT = 3'b010, CS_STOP = 3'b011, CS_DONE = 3'b100
  } tcr_cstate_type;
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_s_q, sda_s_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
    end else begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
    end
  end
  // ---------------------------------------------------------------
  // Two-entry result buffer
  // ---------------------------------------------------------------
  logic [7:0] buf_q [2];   // Storage by index
  logic [1:0] cnt_q;       // Fill level
  logic wptr_q, rptr_q;
  logic in_valid, in_ready, out_ready;
  logic [7:0] in_byte;
  assign in_ready = (cnt_q != 2'd2);
  assign out_ready = i_rd && i_addr == TCR_CMD_DATA;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      buf_q[0] <= 8'h0_000;
      buf_q[1] <= 8'h0_000;
      cnt_q <= 2'd0;
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        buf_q[wptr_q] <= in_byte;
        wptr_q <= ~wptr_q;
      end
      if (out_ready && cnt_q != 2'd0) rptr_q <= ~rptr_q;
      cnt_q <= cnt_q + 2'((in_valid && in_ready) ? 1 : 0) - 2'((out_ready && cnt_q != 2'd0) ? 1 : 0);
    end
  end
  // ---------------------------------------------------------------
  // Bus engine
  // ---------------------------------------------------------------
  tcr_cstate_type st_q;
  logic [8:0] frame_q [4];   // Up to four bytes: data and ack-drive bit
  logic [1:0] nbyte_q, byte_q;
  logic [2:0] mode_q;        // bit0 read frame
  logic [3:0] bit_q;
  logic [15:0] tm_q;
  logic [1:0] ph_q;          // Quarter phase of a bit
  logic scl_oe_q, sda_oe_q;
  logic [7:0] rx_q;
  logic busy_q;
  logic push_q;
  assign in_valid = push_q;
  assign in_byte = rx_q;
  logic tick;
  assign tick = (tm_q == 16'(HALF_CYC - 1));
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= CS_IDLE;
      for (int i = 0; i < 4; i++) frame_q[i] <= 9'h0_000;
      nbyte_q <= 2'd0;
      byte_q <= 2'd0;
      mode_q <= 3'h0;
      bit_q <= 4'h0_000;
      tm_q <= 16'h0_000;
      ph_q <= 2'd0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rx_q <= 8'h0_000;
      busy_q <= 1'b0;
      push_q <= 1'b0;
    end else begin
      push_q <= 1'b0;
      tm_q <= tick ? 16'h0_000 : tm_q + 16'h0_001;
      case (st_q)
        CS_IDLE: begin
          tm_q <= 16'h0_000;
          if (i_wr && i_addr == TCR_CMD_PTR) begin
            // Write address then pointer byte
            frame_q[0] <= {TCR_ADDR_BASE, i_wdata[10:8], 1'b0, 1'b0};
            frame_q[1] <= {i_wdata[7:0], 1'b0};
            nbyte_q <= 2'd1;
            mode_q <= 3'h0;
            st_q <= CS_START;
            busy_q <= 1'b1;
          end else if (i_wr && i_addr == TCR_CMD_READ) begin
            // Address with read bit, then two data bytes
            frame_q[0] <= {TCR_ADDR_BASE, i_wdata[10:8], 1'b1, 1'b0};
            frame_q[1] <= 9'h0_1FF;   // Ack upper byte
            frame_q[2] <= 9'h0_1FE;   // Nak lower byte
            nbyte_q <= 2'd2;
            mode_q <= 3'h1;
            st_q <= CS_START;
            busy_q <= 1'b1;
          end
        end
        CS_START: begin
          if (tick) begin
            sda_oe_q <= 1'b1;
            st_q <= CS_BIT;
            byte_q <= 2'd0;
            bit_q <= 4'h0_000;
            ph_q <= 2'd0;
          end
        end
        CS_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'd1;
            case (ph_q)
              2'd0: begin
                scl_oe_q <= 1'b1;
                // Data or ack driven while clock is low
                sda_oe_q <= bit_q == 4'h0_008 ? (byte_q != 2'd0 && mode_q[0] ? frame_q[byte_q][0] : 1'b0)
                  : ~(frame_q[byte_q][4'd8 - bit_q] | (byte_q != 2'd0 && mode_q[0]));
              end
              2'd1: scl_oe_q <= 1'b0;
              2'd2: begin
                // Wait while device stretches the clock
                if (!scl_s_q[1]) begin
                  ph_q <= 2'd2;
                end else if (bit_q != 4'h0_008) begin
                  rx_q <= {rx_q[6:0], sda_s_q[1]};
                end
              end
              default: begin
                if (bit_q == 4'h0_008 && mode_q[0] && byte_q != 2'd0 && !in_ready) begin
                  // Buffer full: hold the bus here, clock high, until a byte drains
                  ph_q <= 2'd3;
                end else if (bit_q == 4'h0_008) begin
                  bit_q <= 4'h0_000;
                  if (mode_q[0] && byte_q != 2'd0) push_q <= 1'b1;
                  if (byte_q == nbyte_q || (!mode_q[0] && sda_s_q[1])) begin
                    st_q <= CS_STOP;
                  end else begin
                    byte_q <= byte_q + 2'd1;
                  end
                end else begin
                  bit_q <= bit_q + 4'h0_001;
                end
              end
            endcase
          end
        end
        CS_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'd1;
            if (ph_q == 2'd0) begin
              scl_oe_q <= 1'b1;
              sda_oe_q <= 1'b1;
            end else if (ph_q == 2'd1) begin
              scl_oe_q <= 1'b0;
            end else if (ph_q == 2'd2) begin
              sda_oe_q <= 1'b0;
              st_q <= CS_DONE;
            end
          end
        end
        default: begin
          // Frame over; a full buffer has already stalled it byte by byte
          if (!push_q) begin
            st_q <= CS_IDLE;
            busy_q <= 1'b0;
          end
        end
      endcase
    end
  end
  assign link.ctl_scl_oe = scl_oe_q;
  assign link.ctl_sda_oe = sda_oe_q;
  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 16'h0_000;
    end else if (i_rd && i_addr == TCR_CMD_DATA) begin
      o_rdata <= cnt_q != 2'd0 ? {8'h0_001, buf_q[rptr_q]} : 16'h0_000;
    end else if (i_rd && i_addr == TCR_CMD_STAT) begin
      o_rdata <= {13'h0_000, busy_q, cnt_q};
    end else begin
      o_rdata <= 16'h0_000;
    end
  end
endmodule
`default_nettype wire

// File: verification/tcr_link_assertions.sv
// Checker watching the two-wire link between controller and device
`timescale 1ns/10ps
`default_nettype none
module tcr_link_assertions
  import tcr_pkg::*;
#(
  parameter int STRETCH_CYC = TCR_STRETCH_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Pull enables
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_oe,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  // Resolved wires
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------
  // Stretch length counter
  // ----------------------------------------
  localparam int STRETCH_MAX = STRETCH_CYC + 4; // Slack for edge detection lag
  int hold_cnt_q; // Cycles the device has held the clock low
  // Counts a running stretch, clears on release
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_cnt_q <= 0;
    end else if (dev_scl_oe) begin
      hold_cnt_q <= hold_cnt_q + 1;
    end else begin
      hold_cnt_q <= 0;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // Stretch may only start once the clock has already fallen
  property p_stretch_start;
    $rose(dev_scl_oe) |-> !$past(scl);
  endproperty
  a_stretch_start: assert property (p_stretch_start) else $error("stretch began with clock high");
  property p_stretch_min;
    $rose(dev_scl_oe) |=> dev_scl_oe [*8];
  endproperty
  a_stretch_min: assert property (p_stretch_min) else $error("stretch too short");
  property p_stretch_max;
    hold_cnt_q <= STRETCH_MAX;
  endproperty
  a_stretch_max: assert property (p_stretch_max) else $error("stretch too long");
  // Device data may only move while the clock is low
  property p_sda_moves_low;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_sda_moves_low: assert property (p_sda_moves_low) else $error("device data moved with clock high");
  property p_stop_quiet;
    ($rose(sda) && scl && $past(scl)) |-> !dev_sda_oe [*8];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("device drove data after stop");
  property p_start_quiet;
    ($fell(sda) && scl && $past(scl)) |-> !dev_sda_oe [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("device drove data after start");
  // Controller leaves the clock released right after a stop
  property p_idle_after_stop;
    ($rose(sda) && scl && $past(scl)) |-> !ctl_scl_oe [*8];
  endproperty
  a_idle_after_stop: assert property (p_idle_after_stop) else $error("clock pulled right after stop");
  property p_reset_release;
    $rose(i_reset_n) |-> !dev_sda_oe && !dev_scl_oe && !ctl_sda_oe && !ctl_scl_oe;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("bus not released after reset");
endmodule
`default_nettype wire

// File: verification/test_sensor_register_read_port.sv
// Testbench joining controller and device over the two-wire link
`timescale 1ns/10ps
`default_nettype none
module test_sensor_register_read_port;
  import tcr_pkg::*;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [2:0] strap = 3'h5; // Device address strap
  logic [15:0] hot_t = 16'h9A5C; // Sign bit set in upper byte
  logic [15:0] diff_t = 16'h0123;
  logic [15:0] cold_t = 16'h7E81;
  logic [15:0] raw_t = 16'h3C96;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic [5:0] o_pointer;
  int error_cnt = 0;
  int tests_run = 0;
  // 100 MHz system clock
  always #5 i_sys_clk = ~i_sys_clk;
  // ----------------------------------------
  // Both ends and the checker
  // ----------------------------------------
  tcr_link_if u_tcr_link_if ();
  tcr_device u_tcr_device (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr_strap(strap),
    .i_hot_temp(hot_t), .i_diff_temp(diff_t), .i_cold_temp(cold_t), .i_raw_data(raw_t),
    .link(u_tcr_link_if), .o_pointer(o_pointer));
  tcr_controller u_tcr_controller (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(u_tcr_link_if));
  tcr_link_assertions #(.STRETCH_CYC(TCR_STRETCH_CYC)) u_tcr_link_assertions (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .ctl_scl_oe(u_tcr_link_if.ctl_scl_oe), .ctl_sda_oe(u_tcr_link_if.ctl_sda_oe),
    .dev_scl_oe(u_tcr_link_if.dev_scl_oe), .dev_sda_oe(u_tcr_link_if.dev_sda_oe),
    .scl(u_tcr_link_if.scl), .sda(u_tcr_link_if.sda));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // Bounded poll of the busy flag
  task automatic wait_idle();
    logic [15:0] s;
    int n;
    s = 16'h0004;
    n = 0;
    while (s[2] !== 1'b0 && n < 4000) begin
      rd(TCR_CMD_STAT, s);
      n++;
    end
    if (n >= 4000) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, s, 16'h0000);
    end
  endtask
  task automatic set_ptr(input logic [2:0] st, input logic [7:0] p);
    wr(TCR_CMD_PTR, {5'h00, st, p});
    wait_idle();
  endtask
  task automatic pull(input logic [7:0] b);
    logic [15:0] d;
    rd(TCR_CMD_DATA, d);
    chk(d, {8'h01, b});
  endtask
  // Two-byte read, upper byte first
  task automatic read_word(input logic [15:0] w);
    wr(TCR_CMD_READ, {5'h00, strap, 8'h00});
    wait_idle();
    pull(w[15:8]);
    pull(w[7:0]);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [15:0] d;
    chk({10'h000, o_pointer}, 16'h0000);
    rd(TCR_CMD_STAT, d);
    chk(d, 16'h0000);
    rd(TCR_CMD_DATA, d);
    chk(d, 16'h0000);
  endtask
  // Every defined index, with the unimplemented upper pointer bits set
  task automatic t_regs();
    logic [15:0] w [4];
    w[0] = hot_t;
    w[1] = diff_t;
    w[2] = cold_t;
    w[3] = raw_t;
    for (int i = 0; i < 4; i++) begin
      set_ptr(strap, 8'hC0 | 8'(i));
      chk({10'h000, o_pointer}, 16'(i));
      read_word(w[i]);
    end
  endtask
  // No new pointer: the same register again, with a fresh value
  task automatic t_keep();
    @(posedge i_sys_clk);
    raw_t <= 16'h5AA5;
    read_word(16'h5AA5);
  endtask
  task automatic t_undef();
    set_ptr(strap, 8'h2A);
    chk({10'h000, o_pointer}, 16'h002A);
    read_word(16'h0000);
  endtask
  // Foreign address draws no answer: the data line stays released high
  task automatic t_strap();
    logic [15:0] d;
    set_ptr(strap ^ 3'h7, 8'h01);
    chk({10'h000, o_pointer}, 16'h002A);
    wr(TCR_CMD_READ, {5'h00, strap ^ 3'h7, 8'h00});
    wait_idle();
    rd(TCR_CMD_STAT, d);
    chk(d, 16'h0002);
    pull(8'hFF);
    pull(8'hFF);
    rd(TCR_CMD_DATA, d);
    chk(d, 16'h0000);
  endtask
  // Full buffer stalls the second read; no byte may be lost
  task automatic t_stall();
    logic [15:0] d;
    set_ptr(strap, 8'h00);
    wr(TCR_CMD_READ, {5'h00, strap, 8'h00});
    wait_idle();
    rd(TCR_CMD_STAT, d);
    chk(d, 16'h0002);
    @(posedge i_sys_clk);
    hot_t <= 16'hF00F;
    wr(TCR_CMD_READ, {5'h00, strap, 8'h00});
    // Long enough for the engine to reach the upper byte and stall
    repeat (4000) @(posedge i_sys_clk);
    pull(8'h9A);
    pull(8'h5C);
    wait_idle();
    pull(8'hF0);
    pull(8'h0F);
    rd(TCR_CMD_DATA, d);
    chk(d, 16'h0000);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_keep();
    t_undef();
    t_strap();
    t_stall();
    test_done();
  end
  // Roughly half again the expected run length
  initial begin
    repeat (95000) @(posedge i_sys_clk);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
